// File: core/dchi_top.sv
// Purpose: host access logic of a 32-channel DAC, serial or parallel port
// Assumes: sync_cs_n_i and din_i meet setup to the serial clock edges
// Notes:   decoded commands leave through an 8-word FIFO on clk_i
//
// Summary of operation
// [RULE_01] strap low: parallel pins only, serial port fully ignored
// [RULE_02] parallel port issues only acquire-mode channel addressing
// [RULE_03] parallel chip select is active low, shared with frame sync
// [RULE_04] address, offset and all pins captured on write strobe rise
// [RULE_05] five address bits pick one of 32 channels, top bit is MSB
// [RULE_06] offset select high addresses offset channel, address ignored
// [RULE_07] all-channel flag makes all 32 acquire, about 45 us
// [RULE_08] host changes data on rising clock, device samples on falling
// [RULE_09] readback driven on rising edges, 14 valid bits, input ignored
// [RULE_10] host frames 10-bit acquire, 24-bit DAC, 16-clock readback
// [RULE_11] serial words travel most significant bit first
// [RULE_12] host lowers frame sync per transfer, raises it between them
// [RULE_13] byte-wide hosts send two or three bytes, acquire left-justified
// [RULE_14] SPI host idles clock low with phase one
// [RULE_15] output leaves tristate at first rise, returns at 14th fall
// [RULE_16] sync fall resets counter; later edges ignored until count ends
// [RULE_17] host leaves 400 ns between DAC-mode write frames
// [RULE_18] write strobes ignored while chip select is high
`timescale 1ns/1ps

module dchi_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,     // system clock
  input  wire logic             rstn_i,    // async reset, low
  input  wire logic             in_valid_i, // push request
  output logic                  in_ready_o, // not full
  input  wire logic [WIDTH-1:0] in_data_i, // push word
  output logic                  out_valid_o, // not empty
  input  wire logic             out_ready_i, // pop request
  output logic [WIDTH-1:0]      out_data_o // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  // full and empty come straight from the occupancy count
  assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rp_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // pointer wrap handles non power of two depths
  always_comb begin
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_wp = (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + AW'(1);
    end
    if (pop) begin
      nxt_rp = (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + AW'(1);
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + (AW+1)'(1);
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage needs no reset, the count guards it
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data_i;
    end
  end
endmodule

module dchi_top
  import dchi_pkg::*;
(
  input  wire logic        clk_i,             // system clock 25 MHz
  input  wire logic        rstn_i,            // async reset, low
  input  wire logic        sclk_i,            // serial clock from host
  input  wire logic        port_type_strap_i, // high serial, low parallel
  input  wire logic        sync_cs_n_i,       // frame sync / chip select
  input  wire logic        din_i,             // serial data in
  output logic             dout_o,            // serial data out
  output logic             dout_oe_o,         // dout drive enable
  input  wire logic        wr_n_i,            // parallel write strobe
  input  wire logic [4:0]  channel_addr_i,    // parallel channel address
  input  wire logic        offset_sel_i,      // parallel offset select
  input  wire logic        all_chan_i,        // parallel all channels
  output logic             cmd_valid_o,       // command available
  input  wire logic        cmd_ready_i,       // command taken
  output logic             cmd_par_o,         // came from parallel port
  output logic [1:0]       cmd_mode_o,        // mode field
  output logic             cmd_all_o,         // all-channel flag
  output logic             cmd_offset_o,      // offset channel flag
  output logic             cmd_test_o,        // test bit
  output logic [4:0]       cmd_chan_o,        // channel address
  output logic [13:0]      cmd_code_o,        // DAC code
  output logic             acq_busy_o,        // acquisition running
  output logic             overrun_o,         // command lost, sticky
  input  wire logic        overrun_clr_i      // clears overrun_o
);
  // maps offset select and address onto the code store index
  function automatic logic [5:0] chan_idx(input logic offs, input logic [4:0] a);
    chan_idx = offs ? OFFS_CHAN : {1'b0, a}; // [RULE_05] [RULE_06]
  endfunction

  // serial clock domain: falling edges sample, rising edges drive
  logic                strap_m_ff, strap_s_ff, busy_ff, done_ff, rd_pend_ff, tgl_ff, drv_ff;
  logic                nxt_busy, nxt_done, nxt_rd_pend, nxt_tgl, nxt_drv, start, finish;
  logic [4:0]          cnt_ff, nxt_cnt, cnt_inc;
  logic [FRAME_W-1:0]  sh_ff, word_ff, nxt_sh, nxt_word, sh_new;
  logic [CODE_W-1:0]   out_sh_ff, nxt_out_sh, rb_word_ff;

  assign sh_new  = {sh_ff[FRAME_W-2:0], din_i};   // [RULE_11]
  assign cnt_inc = cnt_ff + 5'h01;
  // a frame starts only once the previous one ended and sync rose again
  assign start   = !busy_ff && !done_ff && !sync_cs_n_i && strap_s_ff; // [RULE_01] [RULE_16]

  // falling-edge sampler, counts clocks and closes frames
  always_comb begin
    nxt_busy    = busy_ff;
    nxt_rd_pend = rd_pend_ff;
    nxt_cnt     = cnt_ff;
    nxt_sh      = sh_ff;
    nxt_word    = word_ff;
    nxt_tgl     = tgl_ff;
    finish      = 1'b0;
    if (busy_ff || start) begin
      nxt_busy = 1'b1;
      nxt_cnt  = cnt_inc;
      if (rd_pend_ff) begin
        // readback frame: din is not looked at
        if (cnt_inc == RB_BITS) begin            // [RULE_09] [RULE_15]
          finish      = 1'b1;
          nxt_rd_pend = 1'b0;
        end
      end else begin
        nxt_sh = sh_new;                         // [RULE_08]
        if ((cnt_inc == CMD_BITS && sh_new[MODE_HI:MODE_LO] != DAC_MODE)
            || cnt_inc == DAC_BITS) begin        // [RULE_16]
          finish      = 1'b1;
          nxt_word    = (cnt_inc == DAC_BITS) ? sh_new : {sh_new[CMD_W-1:0], CODE_RST};
          nxt_tgl     = !tgl_ff;
          nxt_rd_pend = (cnt_inc == CMD_BITS) && sh_new[MODE_HI];
        end
      end
      if (finish) begin
        nxt_busy = 1'b0;
        nxt_cnt  = 5'h00;
      end
    end
    nxt_done = done_ff || finish;
  end

  always_ff @(negedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_m_ff <= 1'b0;
      strap_s_ff <= 1'b0;
      busy_ff    <= 1'b0;
      rd_pend_ff <= 1'b0;
      cnt_ff     <= 5'h00;
      sh_ff      <= WORD_RST;
      word_ff    <= WORD_RST;
      tgl_ff     <= 1'b0;
    end else begin
      strap_m_ff <= port_type_strap_i;
      strap_s_ff <= strap_m_ff;
      busy_ff    <= nxt_busy;
      rd_pend_ff <= nxt_rd_pend;
      cnt_ff     <= nxt_cnt;
      sh_ff      <= nxt_sh;
      word_ff    <= nxt_word;
      tgl_ff     <= nxt_tgl;
    end
  end

  // end-of-frame lock; the frame sync rising is what rearms it, since
  // the host clock may stand still while sync is high
  always_ff @(negedge sclk_i or negedge rstn_i or posedge sync_cs_n_i) begin
    if (!rstn_i) begin
      done_ff <= 1'b0;
    end else if (sync_cs_n_i) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;                       // [RULE_16]
    end
  end

  // rising-edge driver for readback data
  always_comb begin
    nxt_drv    = drv_ff;
    nxt_out_sh = out_sh_ff;
    if (!rd_pend_ff) begin
      nxt_drv = 1'b0;
    end else if (!drv_ff && !done_ff && !sync_cs_n_i && strap_s_ff) begin
      nxt_drv    = 1'b1;                         // [RULE_15]
      nxt_out_sh = rb_word_ff;
    end else if (drv_ff) begin
      nxt_out_sh = {out_sh_ff[CODE_W-2:0], 1'b0}; // [RULE_09] [RULE_11]
    end
  end

  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drv_ff    <= 1'b0;
      out_sh_ff <= CODE_RST;
    end else begin
      drv_ff    <= nxt_drv;
      out_sh_ff <= nxt_out_sh;
    end
  end

  // enable drops at the 14th falling edge when the pending flag clears
  assign dout_oe_o = drv_ff && rd_pend_ff;       // [RULE_15]
  assign dout_o    = out_sh_ff[CODE_W-1];

  // system clock domain; pin order: tgl strap wr_n cs_n offs all addr[4:0]
  logic [10:0]         pin_m_ff, pin_s_ff, acq_ff, nxt_acq;
  logic                wr_prev_ff, tgl_prev_ff, ser_evt, par_evt, pend_v_ff, ovr_ff;
  logic                nxt_pend_v, nxt_ovr, fifo_in_ready;
  logic [ENTRY_W-1:0]  evt_entry, pend_ff, nxt_pend, fifo_out;
  logic [CODE_W-1:0]   code_mem_ff [MEM_DEPTH];
  logic [CMD_W-1:0]    ecmd;

  // serial word is stable from its toggle until the next frame ends
  assign ser_evt = (pin_s_ff[10] != tgl_prev_ff) && pin_s_ff[9];    // [RULE_01]
  assign par_evt = !wr_prev_ff && pin_s_ff[8] && !pin_s_ff[7] // [RULE_03] [RULE_04] [RULE_18]
                   && !pin_s_ff[9];                                 // [RULE_01]
  // parallel entries are always acquire mode with test low
  assign evt_entry = ser_evt ? {1'b0, word_ff}
                   : {1'b1, SAMPLE_HOLD_ACQUIRE_MODE, pin_s_ff[5], pin_s_ff[6],
                      1'b0, pin_s_ff[4:0], CODE_RST};              // [RULE_02] [RULE_07]
  assign ecmd = evt_entry[ENTRY_W-2:CODE_W];

  // one-word holding stage in front of the FIFO
  always_comb begin
    nxt_pend_v = pend_v_ff;
    nxt_pend   = pend_ff;
    nxt_acq    = (acq_ff != 11'h000) ? acq_ff - 11'h001 : acq_ff;
    if (pend_v_ff && fifo_in_ready) begin
      nxt_pend_v = 1'b0;
    end
    // a full FIFO stalls the stage; a word arriving then is lost
    if ((ser_evt || par_evt) && !(pend_v_ff && !fifo_in_ready)) begin
      nxt_pend_v = 1'b1;
      nxt_pend   = evt_entry;
    end
    if ((ser_evt || par_evt) && !ecmd[MODE_LO]) begin
      nxt_acq = ecmd[CAL_BIT] ? ACQ_ALL_CYC : ACQ_ONE_CYC;        // [RULE_07]
    end
    // a new loss wins over a clear in the same cycle
    nxt_ovr = (ovr_ff && !overrun_clr_i)
              || ((ser_evt || par_evt) && pend_v_ff && !fifo_in_ready);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_m_ff    <= PIN_RST;
      pin_s_ff    <= PIN_RST;
      wr_prev_ff  <= 1'b1;
      tgl_prev_ff <= 1'b0;
      pend_v_ff   <= 1'b0;
      pend_ff     <= '0;
      ovr_ff      <= 1'b0;
      acq_ff      <= 11'h000;
    end else begin
      pin_m_ff    <= {tgl_ff, port_type_strap_i, wr_n_i, sync_cs_n_i,
                      offset_sel_i, all_chan_i, channel_addr_i};
      pin_s_ff    <= pin_m_ff;
      wr_prev_ff  <= pin_s_ff[8];
      tgl_prev_ff <= pin_s_ff[10];
      pend_v_ff   <= nxt_pend_v;
      pend_ff     <= nxt_pend;
      ovr_ff      <= nxt_ovr;
      acq_ff      <= nxt_acq;
    end
  end

  // code store; readback word held for the serial side
  always_ff @(posedge clk_i) begin
    if (ser_evt && word_ff[FRAME_W-1:FRAME_W-2] == DAC_MODE) begin
      code_mem_ff[chan_idx(word_ff[CODE_W+OFFS_BIT], word_ff[CODE_W+4:CODE_W])]
        <= word_ff[CODE_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rb_word_ff <= CODE_RST;
    end else if (ser_evt && word_ff[FRAME_W-1]) begin
      rb_word_ff <= code_mem_ff[chan_idx(word_ff[CODE_W+OFFS_BIT],
                                         word_ff[CODE_W+4:CODE_W])]; // [RULE_09]
    end
  end

  dchi_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (pend_v_ff),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pend_ff),
    .out_valid_o (cmd_valid_o),
    .out_ready_i (cmd_ready_i),
    .out_data_o  (fifo_out)
  );

  // field split of the head entry
  assign cmd_par_o    = fifo_out[ENTRY_W-1];
  assign cmd_mode_o   = fifo_out[CODE_W+MODE_HI:CODE_W+MODE_LO];
  assign cmd_all_o    = fifo_out[CODE_W+CAL_BIT];
  assign cmd_offset_o = fifo_out[CODE_W+OFFS_BIT];
  assign cmd_test_o   = fifo_out[CODE_W+TEST_BIT];
  assign cmd_chan_o   = fifo_out[CODE_W+4:CODE_W];
  assign cmd_code_o   = fifo_out[CODE_W-1:0];
  assign acq_busy_o   = (acq_ff != 11'h000);
  assign overrun_o    = ovr_ff;
endmodule

// File: core/dchi_pkg.sv
// Purpose: shared constants and types of the DAC channel host port
// Assumes: 25 MHz system clock, serial clock supplied by the host
// Notes:   command word is mode[9:8] cal[7] offs[6] test[5] addr[4:0]
package dchi_pkg;
  localparam int        CHAN_W     = 5;
  localparam int        CODE_W     = 14;
  localparam int        CMD_W      = 10;
  localparam int        FRAME_W    = 24;
  localparam int        ENTRY_W    = 25;
  localparam int        FIFO_DEPTH = 8;
  localparam int        MEM_DEPTH  = 33;
  localparam logic [5:0] OFFS_CHAN = 6'h20;
  // serial frame lengths in clocks
  localparam logic [4:0] CMD_BITS  = 5'h0A;
  localparam logic [4:0] DAC_BITS  = 5'h18;
  localparam logic [4:0] RB_BITS   = 5'h0E;
  // field positions inside the 10-bit command
  localparam int        MODE_HI    = 9;
  localparam int        MODE_LO    = 8;
  localparam int        CAL_BIT    = 7;
  localparam int        OFFS_BIT   = 6;
  localparam int        TEST_BIT   = 5;
  // acquisition times
  localparam int        CLK_MHZ    = 25;
  localparam int        ACQ_ONE_US = 16;
  localparam int        ACQ_ALL_US = 45;
  localparam logic [10:0] ACQ_ONE_CYC = 11'(ACQ_ONE_US * CLK_MHZ);
  localparam logic [10:0] ACQ_ALL_CYC = 11'(ACQ_ALL_US * CLK_MHZ);
  // reset values
  localparam logic [10:0] PIN_RST  = 11'h180;
  localparam logic [13:0] CODE_RST = 14'h0000;
  localparam logic [23:0] WORD_RST = 24'h000000;
  typedef enum logic [1:0] {
    SAMPLE_HOLD_ACQUIRE_MODE = 2'b00,
    DAC_MODE                 = 2'b01,
    ACQ_READBACK_MODE        = 2'b10,
    READBACK_MODE            = 2'b11
  } dchi_mode_t;
endpackage

// File: tb/dchi_props.sv
// Purpose: pin checks of the dac host port
// Assumes: strap moved only while idle
// Notes:   a new command restarts the timer, so span is a range
`timescale 1ns/1ps
module dchi_props (
  input wire logic        clk_i,             // clock
  input wire logic        rstn_i,            // reset
  input wire logic        sclk_i,            // link clock
  input wire logic        port_type_strap_i, // strap
  input wire logic        dout_o,            // data out
  input wire logic        dout_oe_o,         // drive
  input wire logic        cmd_valid_o,       // valid
  input wire logic        cmd_ready_i,       // pop
  input wire logic        cmd_par_o,         // parallel
  input wire logic [1:0]  cmd_mode_o,        // mode
  input wire logic        cmd_test_o,        // test
  input wire logic [4:0]  cmd_chan_o,        // channel
  input wire logic [13:0] cmd_code_o,        // code
  input wire logic        acq_busy_o,        // timer
  input wire logic        overrun_o,         // lost
  input wire logic        overrun_clr_i      // clear
);
  logic [10:0] busy_cnt_ff;
  logic [10:0] nxt_busy_cnt;
  // length of the running busy stretch
  always_comb nxt_busy_cnt = acq_busy_o ? busy_cnt_ff + 11'h001 : 11'h000;
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i) busy_cnt_ff <= 11'h000;
    else busy_cnt_ff <= nxt_busy_cnt;

  chk_serial_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !port_type_strap_i && !$past(port_type_strap_i, 8) |-> !dout_oe_o)
    else $error("readback driven while parallel");
  chk_par_acquire: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cmd_valid_o && cmd_par_o |-> cmd_mode_o == 2'h0 && !cmd_test_o && cmd_code_o == 14'h0000)
    else $error("parallel entry not a plain acquire");
  chk_head_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_chan_o))
    else $error("head entry moved before pop");
  chk_timer_span: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $fell(acq_busy_o) |-> busy_cnt_ff >= 11'h190 && busy_cnt_ff <= 11'h4B0)
    else $error("acquire time out of range");
  chk_oe_window: assert property (@(negedge sclk_i) disable iff (!rstn_i)
    $rose(dout_oe_o) |=> dout_oe_o [*8] ##1 dout_oe_o [*5] ##1 !dout_oe_o)
    else $error("readback drive not 14 clocks");
  chk_dout_rise: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $changed(dout_o) && dout_oe_o |-> sclk_i)
    else $error("readback bit moved off a rising edge");
  chk_ovr_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i)
    overrun_o && !overrun_clr_i |=> overrun_o)
    else $error("overrun dropped by itself");
  chk_ovr_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    overrun_clr_i && !cmd_valid_o |=> !overrun_o)
    else $error("overrun not cleared");
  cov_readback: cover property (@(negedge sclk_i) $rose(dout_oe_o));
  cov_all_acq: cover property (@(posedge clk_i) $fell(acq_busy_o) && busy_cnt_ff == 11'h465);
  cov_overrun: cover property (@(posedge clk_i) $rose(overrun_o));
endmodule
bind dchi_top dchi_props dchi_props_inst (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk_i),
  .port_type_strap_i(port_type_strap_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
  .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i), .cmd_par_o(cmd_par_o),
  .cmd_mode_o(cmd_mode_o), .cmd_test_o(cmd_test_o), .cmd_chan_o(cmd_chan_o),
  .cmd_code_o(cmd_code_o), .acq_busy_o(acq_busy_o), .overrun_o(overrun_o),
  .overrun_clr_i(overrun_clr_i));

// File: tb/dchi_host_model.sv
// Purpose: serial host on the link
// Assumes: 125 ns link clock, still and low between frames
// Notes:   released readback line reads inverted
`timescale 1ns/1ps
module dchi_host_model (
  output logic      sclk_o,   // link clock
  output logic      sync_n_o, // frame sync
  output logic      din_o,    // data to device
  input  wire logic dout_i,   // data from device
  input  wire logic oe_i      // device drives
);
  logic last_q;
  wire  line_w = oe_i ? dout_i : ~last_q;
  // a floating line must not repeat the last bit
  always @(dout_i or oe_i) if (oe_i) last_q = dout_i;
  // idle: clock low, no frame
  initial {sclk_o, sync_n_o, din_o, last_q} = 4'h4;
  // sync high clocks let the strap settle
  task automatic idle_clocks();
    #13;
    repeat (2) begin
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
  endtask
  // parallel chip select shares the frame sync pin, so only this model drives it
  task automatic set_sync(input logic lvl);
    sync_n_o = lvl;
  endtask
  // one frame of n clocks, msb first
  task automatic frame(input logic [23:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    #17 sync_n_o = 1'b0;
    #30;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b1;
      #5 din_o = w[i];
      #57.5 rd = {rd[14:0], line_w};
      sclk_o = 1'b0;
      #62.5;
    end
    din_o = ~din_o;
    #20 sync_n_o = 1'b1;
    #450;
  endtask
endmodule

// File: tb/dchi_top_tb.sv
// Purpose: self-checking bench of the dac host port
// Assumes: host model owns the link pins
// Notes:   parallel pins move on falling clk edges
`timescale 1ns/1ps
module dchi_top_tb
  import dchi_pkg::*;
;
  logic        clk_i, rstn_i, strap, wr_n, offs, all_ch, ready, clr;
  logic [4:0]  addr;
  logic [15:0] rd;
  int          miscompares = 0, cmp_count = 0, busy_run = 0, busy_last = 0;
  wire         sclk, sync_n, din, dout, oe, v, par, ca, co, ct, busy, ovr;
  wire  [1:0]  mode;
  wire  [4:0]  chan;
  wire  [13:0] code;

  dchi_top dchi_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk),
    .port_type_strap_i(strap), .sync_cs_n_i(sync_n), .din_i(din), .dout_o(dout),
    .dout_oe_o(oe), .wr_n_i(wr_n), .channel_addr_i(addr), .offset_sel_i(offs),
    .all_chan_i(all_ch), .cmd_valid_o(v), .cmd_ready_i(ready), .cmd_par_o(par),
    .cmd_mode_o(mode), .cmd_all_o(ca), .cmd_offset_o(co), .cmd_test_o(ct),
    .cmd_chan_o(chan), .cmd_code_o(code), .acq_busy_o(busy), .overrun_o(ovr),
    .overrun_clr_i(clr));
  dchi_host_model dchi_host_model_inst (.sclk_o(sclk), .sync_n_o(sync_n), .din_o(din),
    .dout_i(dout), .oe_i(oe));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // length of the last finished busy stretch, sampled off the launching edge
  always @(negedge clk_i) begin
    if (busy === 1'b1) busy_run++;
    else if (busy_run != 0) begin
      busy_last = busy_run;
      busy_run = 0;
    end
  end

  task automatic chk(input string nm, input logic [24:0] e, input logic [24:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // sel 0 waits for a command, 1 for the timer to stop
  task automatic wait_on(input int sel, input int lim);
    int n = 0;
    while (sel ? busy !== 1'b0 : v !== 1'b1) begin
      @(negedge clk_i);
      if (++n > lim) begin
        chk("wait limit", 0, 1);
        conclude();
      end
    end
    if (sel) @(negedge clk_i);
  endtask
  // compare the head entry, then pop it
  task automatic chk_cmd(input logic p, m1, m0, a, o, input logic [4:0] c, input logic [13:0] d);
    wait_on(0, 12);
    chk("command", {p, m1, m0, a, o, 1'b0, o ? 5'h00 : c, d},
        {par, mode, ca, co, ct, o ? 5'h00 : chan, code});
    @(negedge clk_i) ready = 1'b1;
    @(negedge clk_i) ready = 1'b0;
  endtask
  // strobe held 3 clocks; pins change 4 clocks after the rise
  task automatic par_wr(input logic cs_n, input logic [4:0] a, input logic o, al);
    @(negedge clk_i);
    dchi_host_model_inst.set_sync(cs_n);
    {addr, offs, all_ch, wr_n} = {a, o, al, 1'b0};
    repeat (3) @(negedge clk_i);
    wr_n = 1'b1;
    repeat (4) @(negedge clk_i);
    {addr, offs, all_ch} = {~a, 2'h0};
    dchi_host_model_inst.set_sync(1'b1);
  endtask
  task automatic do_reset();
    rstn_i = 1'b0;
    repeat (10) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic t_par();
    logic [4:0] a [4] = '{5'h00, 5'h15, 5'h1F, 5'h0A};
    strap = 1'b0;
    dchi_host_model_inst.idle_clocks();
    for (int i = 0; i < 4; i++) begin
      par_wr(1'b0, a[i], i == 2, i == 3);
      chk_cmd(1'b1, 1'b0, 1'b0, i == 3, i == 2, a[i], 14'h0000);
      wait_on(1, 1300);
      chk("busy span", i == 3 ? ACQ_ALL_CYC : ACQ_ONE_CYC, busy_last);
    end
    par_wr(1'b1, 5'h11, 1'b0, 1'b0);
    repeat (8) @(negedge clk_i);
    chk("strobe unselected", 0, v);
    dchi_host_model_inst.frame(24'h000011, 10, rd);
    repeat (8) @(negedge clk_i);
    chk("serial when parallel", 0, v);
    $display("parallel test done");
  endtask

  task automatic t_ser();
    logic [1:0] m;
    strap = 1'b1;
    dchi_host_model_inst.idle_clocks();
    dchi_host_model_inst.frame({DAC_MODE, 3'h0, 5'h13, 14'h2A5C}, 24, rd);
    chk_cmd(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 5'h13, 14'h2A5C);
    for (int k = 0; k < 2; k++) begin
      m = k ? ACQ_READBACK_MODE : READBACK_MODE;
      dchi_host_model_inst.frame({14'h0000, m, 3'h0, 5'h13}, 10, rd);
      chk_cmd(1'b0, m[1], m[0], 1'b0, 1'b0, 5'h13, 14'h0000);
      if (k) wait_on(1, 500);
      dchi_host_model_inst.frame(24'hFFFFFF, 16, rd);
      chk("readback word", 14'h2A5C, rd[15:2]);
      repeat (8) @(negedge clk_i);
      chk("readback adds none", 0, v);
    end
    dchi_host_model_inst.frame({8'h00, 10'h087, 6'h00}, 16, rd);
    chk_cmd(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 5'h07, 14'h0000);
    wait_on(1, 1300);
    chk("all span", ACQ_ALL_CYC, busy_last);
    $display("serial test done");
  endtask

  task automatic t_ovr();
    strap = 1'b0;
    dchi_host_model_inst.idle_clocks();
    for (int i = 0; i < 10; i++) par_wr(1'b0, 5'(i), 1'b0, 1'b0);
    repeat (8) @(negedge clk_i);
    chk("overrun set", 1, ovr);
    for (int i = 0; i < 9; i++) chk_cmd(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5'(i), 14'h0000);
    chk("overrun held", 1, ovr);
    @(negedge clk_i) clr = 1'b1;
    @(negedge clk_i) clr = 1'b0;
    chk("overrun cleared", 0, ovr);
    par_wr(1'b0, 5'h1C, 1'b0, 1'b0);
    do_reset();
    chk("after reset", 0, {v, busy, ovr});
    $display("overrun test done");
  endtask

  // parallel, serial, then overflow and a second reset
  initial begin
    {rstn_i, strap, wr_n, addr, offs, all_ch, ready, clr} = {3'h1, 5'h00, 4'h0};
    do_reset();
    t_par();
    t_ser();
    t_ovr();
    conclude();
  end
endmodule
